// ===== rtl/cbe_map.vh
/*
 * Constants shared by the execution core: register offsets, command word
 * fields, status flag positions, operation codes, reset values and cycle
 * figures. Assumes it is included by bare name from rtl/ files.
 */
`ifndef CBE_MAP_VH
`define CBE_MAP_VH

// **********************************************************
// Register offsets (byte addresses on the control bus)
// **********************************************************
`define CBE_OFF_CMD 8'h00
`define CBE_OFF_FLAGS 8'h04
`define CBE_OFF_PC 8'h08
`define CBE_OFF_STATUS 8'h0c
`define CBE_OFF_GPR 8'h80

// **********************************************************
// Command word fields
// **********************************************************
`define CBE_CMD_OP 4:0
`define CBE_CMD_D 9:5
`define CBE_CMD_R 14:10
`define CBE_CMD_B 17:15
`define CBE_CMD_K 25:18
`define CBE_CMD_P 27:26

// **********************************************************
// Status flag positions and status word bits
// **********************************************************
`define CBE_F_C 0
`define CBE_F_Z 1
`define CBE_F_N 2
`define CBE_F_V 3
`define CBE_F_S 4
`define CBE_F_H 5
`define CBE_F_T 6
`define CBE_F_I 7
`define CBE_ST_BUSY 0
`define CBE_ST_ILLEGAL 1
`define CBE_ST_CYC 5:4

// **********************************************************
// Reset values, cycle figures, bus responses
// **********************************************************
`define CBE_CMD_RST 32'h0000_0000
`define CBE_FLAGS_RST 8'h00
`define CBE_PC_RST 16'h0000
`define CBE_CYC_ONE 2'd1
`define CBE_CYC_TWO 2'd2
`define CBE_RESP_OKAY 2'b00
`define CBE_RESP_SLVERR 2'b10
`define CBE_RESP_DECERR 2'b11

// **********************************************************
// Operation codes
// **********************************************************
`define CBE_OP_NOP 5'h00
`define CBE_OP_BRANCH_HALF_CARRY_CLEAR 5'h01
`define CBE_OP_BRANCH_TRANSFER_SET 5'h02
`define CBE_OP_BRANCH_TRANSFER_CLEAR 5'h03
`define CBE_OP_BRANCH_OVERFLOW_SET 5'h04
`define CBE_OP_BRANCH_OVERFLOW_CLEAR 5'h05
`define CBE_OP_BRANCH_IRQ_ENABLED 5'h06
`define CBE_OP_BRANCH_IRQ_DISABLED 5'h07
`define CBE_OP_IO_BIT_SET 5'h08
`define CBE_OP_IO_BIT_CLEAR 5'h09
`define CBE_OP_LOGICAL_LEFT_SHIFT 5'h0c
`define CBE_OP_LOGICAL_RIGHT_SHIFT 5'h0d
`define CBE_OP_ROTATE_RIGHT_CARRY 5'h0e
`define CBE_OP_ARITHMETIC_RIGHT_SHIFT 5'h0f
`define CBE_OP_NIBBLE_EXCHANGE 5'h10
`define CBE_OP_STATUS_FLAG_SET 5'h11
`define CBE_OP_STATUS_FLAG_CLEAR 5'h12
`define CBE_OP_OVERFLOW_FLAG_CLEAR 5'h13
`define CBE_OP_HALF_CARRY_SET 5'h14
`define CBE_OP_BIT_TO_TRANSFER_FLAG 5'h15
`define CBE_OP_TRANSFER_FLAG_TO_BIT 5'h16
`define CBE_OP_REGISTER_COPY 5'h17
`define CBE_OP_REGISTER_PAIR_COPY 5'h18
`define CBE_OP_LOAD_IMMEDIATE 5'h19
`define CBE_OP_INDIRECT_LOAD 5'h1a
`define CBE_OP_INDIRECT_LOAD_INC 5'h1b
`define CBE_OP_INDIRECT_LOAD_DEC 5'h1c
`define CBE_OP_DISPLACED_INDIRECT_LOAD 5'h1d

// Shift kinds match the two low bits of the shift operation codes
`define CBE_SH_LEFT 2'd0
`define CBE_SH_RIGHT 2'd1
`define CBE_SH_ROTATE 2'd2
`define CBE_SH_ARITH 2'd3

`endif

// ===== rtl/cbe_gpr.v
/*
 * General register file: 32 bytes, one byte read port and two pair read
 * ports, all registered, plus a byte and a pair write port.
 * Assumes a single clock; reads return the value before same-edge writes.
 */
`timescale 1ns/1ps
module cbe_gpr (
	input wire aclk,
	input wire [4:0] a_addr,
	output reg [7:0] a_data,
	input wire [3:0] b_pair,
	output reg [15:0] b_data,
	input wire [3:0] c_pair,
	output reg [15:0] c_data,
	input wire wb_en,
	input wire [4:0] wb_addr,
	input wire [7:0] wb_data,
	input wire ww_en,
	input wire [3:0] ww_pair,
	input wire [15:0] ww_data
);

reg [7:0] mem [0:31];

always @(posedge aclk) begin
	a_data <= mem[a_addr];
	b_data <= {mem[{b_pair, 1'b1}], mem[{b_pair, 1'b0}]};
	c_data <= {mem[{c_pair, 1'b1}], mem[{c_pair, 1'b0}]};
	if (ww_en) begin
		mem[{ww_pair, 1'b0}] <= ww_data[7:0];
		mem[{ww_pair, 1'b1}] <= ww_data[15:8];
	end
	// Byte port written last so it wins when both hit one byte
	if (wb_en) begin
		mem[wb_addr] <= wb_data;
	end
end

endmodule // cbe_gpr

// ===== rtl/cbe_shift.v
/*
 * Shift and rotate unit with its flag results.
 * Assumes purely combinational use by the execution core.
 */
`timescale 1ns/1ps
`include "cbe_map.vh"
module cbe_shift (
	input wire [1:0] kind,
	input wire [7:0] value,
	input wire carry_in,
	output reg [7:0] result,
	output reg carry_out,
	output wire zero,
	output wire negative,
	output wire overflow
);

always @* begin
	case (kind)
	`CBE_SH_LEFT: begin
		result = {value[6:0], 1'b0};
		carry_out = value[7];
	end
	`CBE_SH_RIGHT: begin
		result = {1'b0, value[7:1]};
		carry_out = value[0];
	end
	`CBE_SH_ROTATE: begin
		result = {carry_in, value[7:1]};
		carry_out = value[0];
	end
	default: begin
		result = {value[7], value[7:1]};
		carry_out = value[0];
	end
	endcase
end

assign zero = (result == 8'h00);
assign negative = result[7];
// Overflow after a shift is the sign of the result against the carry out
assign overflow = result[7] ^ carry_out;

endmodule // cbe_shift

// ===== rtl/cbe_core.v
/*
 * Execution core for branches on status flags, I/O bit set and clear,
 * shifts, flag set and clear, transfer-bit moves, register moves and
 * indirect loads. Software issues one command word at a time over
 * AXI4-Lite. Assumes data memory and I/O space on the same clock that
 * answer a read strobe with data in the same cycle.
 */
`timescale 1ns/1ps
`include "cbe_map.vh"

// Notes on behaviour
// - Half-carry clear branch: pc gets pc+k+1; one cycle, two when taken.
// - Transfer-bit set/clear branches jump to pc+k+1; one or two cycles.
// - Overflow set/clear branches jump to pc+k+1; one or two cycles.
// - Interrupt enabled/disabled branches jump to pc+k+1; one or two cycles.
// - I/O bit set/clear forces one bit; two cycles; flags unchanged.
// - Logical left shift fills bit zero with zero; sets Z,C,N,V; one cycle.
// - Logical right shift fills bit seven with zero; sets Z,C,N,V; one cycle.
// - Rotate right: old carry into bit seven, bit zero to carry; one cycle.
// - Arithmetic right shift keeps bit seven; sets Z,C,N,V; one cycle.
// - Each status flag has a one-cycle set and clear touching only it.
// - Dedicated overflow clear, one cycle, leaves other flags alone.
// - Bit store copies a register bit into the transfer flag; one cycle.
// - Bit load copies the transfer flag into a register bit; one cycle.
// - Post-increment load reads at the pointer then bumps it; two cycles.
// - Pre-decrement load drops the pointer then reads there; two cycles.
// - Displaced load reads at pointer plus offset, pointer kept; two cycles.
module cbe_core (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] awaddr,
	input wire [2:0] awprot,
	input wire awvalid,
	output wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output wire wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [7:0] araddr,
	input wire [2:0] arprot,
	input wire arvalid,
	output wire arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	output reg [15:0] dmem_addr,
	output reg dmem_rd,
	input wire [7:0] dmem_rdata,
	output reg [5:0] io_addr,
	output reg io_rd,
	input wire [7:0] io_rdata,
	output reg io_wr,
	output reg [7:0] io_wdata
);

localparam ST_IDLE = 2'd0;
localparam ST_EXEC = 2'd1;
localparam ST_SECOND = 2'd2;

// **********************************************************
// Helpers
// **********************************************************
function [31:0] merge;
	input [31:0] old;
	input [31:0] fresh;
	input [3:0] strb;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = fresh[i*8 +: 8];
			end
		end
	end
endfunction

function branch_taken;
	input [4:0] op;
	input [7:0] f;
	begin
		case (op)
		`CBE_OP_BRANCH_HALF_CARRY_CLEAR: branch_taken = ~f[`CBE_F_H];
		`CBE_OP_BRANCH_TRANSFER_SET: branch_taken = f[`CBE_F_T];
		`CBE_OP_BRANCH_TRANSFER_CLEAR: branch_taken = ~f[`CBE_F_T];
		`CBE_OP_BRANCH_OVERFLOW_SET: branch_taken = f[`CBE_F_V];
		`CBE_OP_BRANCH_OVERFLOW_CLEAR: branch_taken = ~f[`CBE_F_V];
		`CBE_OP_BRANCH_IRQ_ENABLED: branch_taken = f[`CBE_F_I];
		`CBE_OP_BRANCH_IRQ_DISABLED: branch_taken = ~f[`CBE_F_I];
		default: branch_taken = 1'b0;
		endcase
	end
endfunction

// Pointer select 0, 1, 2 picks pairs 13, 14, 15; 3 also picks 15
function [3:0] ptr_pair;
	input [1:0] sel;
	begin
		ptr_pair = (sel == 2'd3) ? 4'hf : 4'hd + {2'b00, sel};
	end
endfunction

// **********************************************************
// Declarations
// **********************************************************
reg [1:0] state;
reg [31:0] cmd;
reg [7:0] flags;
reg [15:0] pc;
reg [1:0] cycles;
reg illegal;
reg [15:0] ptr_new;
reg rd_pend;
reg [7:0] rd_addr;
reg wb_en;
reg [4:0] wb_addr;
reg [7:0] wb_data;
reg ww_en;
reg [3:0] ww_pair;
reg [15:0] ww_data;
wire idle = (state == ST_IDLE);
wire [31:0] next_cmd = merge(cmd, wdata, wstrb);
wire [31:0] cur_cmd = idle ? next_cmd : cmd;
wire [4:0] op = cmd[`CBE_CMD_OP];
wire [2:0] bsel = cmd[`CBE_CMD_B];
wire [7:0] kval = cmd[`CBE_CMD_K];
wire [7:0] bmask = 8'h01 << bsel;
wire [7:0] wa = {awaddr[7:2], 2'b00};
wire [7:0] ra = {araddr[7:2], 2'b00};
wire wr_take = awvalid & wvalid & ~bvalid;
wire rd_take = arvalid & arready;
wire cmd_take = wr_take & idle & (wa == `CBE_OFF_CMD);
wire gpr_wr = wr_take & idle & wa[7] & wstrb[0];
wire is_load = (op >= `CBE_OP_INDIRECT_LOAD) & (op <= `CBE_OP_DISPLACED_INDIRECT_LOAD);
wire is_io = (op == `CBE_OP_IO_BIT_SET) | (op == `CBE_OP_IO_BIT_CLEAR);
wire [4:0] a_addr = rd_take ? araddr[6:2] : cur_cmd[`CBE_CMD_D];
wire [7:0] qa;
wire [15:0] qb;
wire [15:0] qc;
wire [7:0] rr_byte = cmd[10] ? qb[15:8] : qb[7:0];
wire [15:0] k_off = {{9{kval[6]}}, kval[6:0]};
wire [7:0] sh_res;
wire sh_c;
wire sh_z;
wire sh_n;
wire sh_v;

// Only the command register uses all four write lanes, reads need the core
// idle only for general registers since those share the byte read port
assign awready = wr_take;
assign wready = wr_take;
assign arready = ~rvalid & ~rd_pend & ~wr_take & (~araddr[7] | idle);

// **********************************************************
// Write response
// **********************************************************
always @(posedge aclk) begin
	if (!aresetn) begin
		bvalid <= 1'b0;
		bresp <= `CBE_RESP_OKAY;
	end else if (wr_take) begin
		bvalid <= 1'b1;
		if (wa == `CBE_OFF_STATUS) begin
			bresp <= `CBE_RESP_SLVERR;
		end else if (wa[7] | (wa == `CBE_OFF_CMD) | (wa == `CBE_OFF_FLAGS)
			| (wa == `CBE_OFF_PC)) begin
			// A write during execution is refused so state stays coherent
			bresp <= idle ? `CBE_RESP_OKAY : `CBE_RESP_SLVERR;
		end else begin
			bresp <= `CBE_RESP_DECERR;
		end
	end else if (bready) begin
		bvalid <= 1'b0;
	end
end

// **********************************************************
// Read path
// **********************************************************
always @(posedge aclk) begin
	if (!aresetn) begin
		rd_pend <= 1'b0;
		rd_addr <= 8'h00;
		rvalid <= 1'b0;
		rresp <= `CBE_RESP_OKAY;
		rdata <= 32'h0000_0000;
	end else if (rd_take) begin
		rd_pend <= 1'b1;
		rd_addr <= ra;
	end else if (rd_pend) begin
		rd_pend <= 1'b0;
		rvalid <= 1'b1;
		rresp <= `CBE_RESP_OKAY;
		if (rd_addr[7]) begin
			rdata <= {24'h000000, qa};
		end else begin
			case (rd_addr)
			`CBE_OFF_CMD: rdata <= cmd;
			`CBE_OFF_FLAGS: rdata <= {24'h000000, flags};
			`CBE_OFF_PC: rdata <= {16'h0000, pc};
			`CBE_OFF_STATUS: rdata <= {26'h0000000, cycles, 2'b00, illegal, ~idle};
			default: begin
				rdata <= 32'h0000_0000;
				rresp <= `CBE_RESP_DECERR;
			end
			endcase
		end
	end else if (rready) begin
		rvalid <= 1'b0;
	end
end

// **********************************************************
// Execution sequence
// **********************************************************
always @(posedge aclk) begin
	if (!aresetn) begin
		state <= ST_IDLE;
		cmd <= `CBE_CMD_RST;
		flags <= `CBE_FLAGS_RST;
		pc <= `CBE_PC_RST;
		cycles <= 2'd0;
		illegal <= 1'b0;
		ptr_new <= 16'h0000;
		dmem_addr <= 16'h0000;
		dmem_rd <= 1'b0;
		io_addr <= 6'h00;
		io_rd <= 1'b0;
		io_wr <= 1'b0;
		io_wdata <= 8'h00;
	end else begin
		dmem_rd <= 1'b0;
		io_rd <= 1'b0;
		io_wr <= 1'b0;
		case (state)
		ST_IDLE: begin
			if (cmd_take) begin
				cmd <= next_cmd;
				illegal <= 1'b0;
				state <= ST_EXEC;
			end else if (wr_take & (wa == `CBE_OFF_FLAGS) & wstrb[0]) begin
				flags <= wdata[7:0];
			end else if (wr_take & (wa == `CBE_OFF_PC)) begin
				pc <= {wstrb[1] ? wdata[15:8] : pc[15:8], wstrb[0] ? wdata[7:0] : pc[7:0]};
			end
		end
		ST_EXEC: begin
			state <= ST_IDLE;
			cycles <= `CBE_CYC_ONE;
			pc <= pc + 16'h0001;
			case (op)
			`CBE_OP_NOP: ;
			`CBE_OP_BRANCH_HALF_CARRY_CLEAR, `CBE_OP_BRANCH_TRANSFER_SET,
			`CBE_OP_BRANCH_TRANSFER_CLEAR, `CBE_OP_BRANCH_OVERFLOW_SET,
			`CBE_OP_BRANCH_OVERFLOW_CLEAR, `CBE_OP_BRANCH_IRQ_ENABLED,
			`CBE_OP_BRANCH_IRQ_DISABLED: begin
				if (branch_taken(op, flags)) begin
					pc <= pc + k_off + 16'h0001;
					state <= ST_SECOND;
				end
			end
			`CBE_OP_IO_BIT_SET, `CBE_OP_IO_BIT_CLEAR: begin
				io_addr <= kval[5:0];
				io_rd <= 1'b1;
				state <= ST_SECOND;
			end
			`CBE_OP_LOGICAL_LEFT_SHIFT, `CBE_OP_LOGICAL_RIGHT_SHIFT,
			`CBE_OP_ROTATE_RIGHT_CARRY, `CBE_OP_ARITHMETIC_RIGHT_SHIFT: begin
				flags[`CBE_F_C] <= sh_c;
				flags[`CBE_F_Z] <= sh_z;
				flags[`CBE_F_N] <= sh_n;
				flags[`CBE_F_V] <= sh_v;
			end
			`CBE_OP_STATUS_FLAG_SET: flags[bsel] <= 1'b1;
			`CBE_OP_STATUS_FLAG_CLEAR: flags[bsel] <= 1'b0;
			`CBE_OP_OVERFLOW_FLAG_CLEAR: flags[`CBE_F_V] <= 1'b0;
			`CBE_OP_HALF_CARRY_SET: flags[`CBE_F_H] <= 1'b1;
			`CBE_OP_BIT_TO_TRANSFER_FLAG: flags[`CBE_F_T] <= qa[bsel];
			`CBE_OP_NIBBLE_EXCHANGE, `CBE_OP_TRANSFER_FLAG_TO_BIT,
			`CBE_OP_REGISTER_COPY, `CBE_OP_REGISTER_PAIR_COPY,
			`CBE_OP_LOAD_IMMEDIATE: ;
			`CBE_OP_INDIRECT_LOAD, `CBE_OP_INDIRECT_LOAD_INC,
			`CBE_OP_INDIRECT_LOAD_DEC, `CBE_OP_DISPLACED_INDIRECT_LOAD: begin
				dmem_rd <= 1'b1;
				state <= ST_SECOND;
				ptr_new <= qc;
				dmem_addr <= qc;
				if (op == `CBE_OP_INDIRECT_LOAD_INC) begin
					ptr_new <= qc + 16'h0001;
				end else if (op == `CBE_OP_INDIRECT_LOAD_DEC) begin
					ptr_new <= qc - 16'h0001;
					dmem_addr <= qc - 16'h0001;
				end else if (op == `CBE_OP_DISPLACED_INDIRECT_LOAD) begin
					dmem_addr <= qc + {10'h000, kval[5:0]};
				end
			end
			default: illegal <= 1'b1;
			endcase
		end
		ST_SECOND: begin
			state <= ST_IDLE;
			cycles <= `CBE_CYC_TWO;
			if (is_io) begin
				// The write is posted: it reaches the port in the following cycle
				io_wr <= 1'b1;
				io_wdata <= (op == `CBE_OP_IO_BIT_SET) ? (io_rdata | bmask)
					: (io_rdata & ~bmask);
			end
		end
		default: state <= ST_IDLE;
		endcase
	end
end

// **********************************************************
// Register file write steering
// **********************************************************
always @* begin
	wb_en = 1'b0;
	wb_addr = cmd[`CBE_CMD_D];
	wb_data = 8'h00;
	ww_en = 1'b0;
	ww_pair = cmd[9:6];
	ww_data = qb;
	if (state == ST_EXEC) begin
		case (op)
		`CBE_OP_LOGICAL_LEFT_SHIFT, `CBE_OP_LOGICAL_RIGHT_SHIFT,
		`CBE_OP_ROTATE_RIGHT_CARRY, `CBE_OP_ARITHMETIC_RIGHT_SHIFT: begin
			wb_en = 1'b1;
			wb_data = sh_res;
		end
		`CBE_OP_NIBBLE_EXCHANGE: begin
			wb_en = 1'b1;
			wb_data = {qa[3:0], qa[7:4]};
		end
		`CBE_OP_TRANSFER_FLAG_TO_BIT: begin
			wb_en = 1'b1;
			wb_data = flags[`CBE_F_T] ? (qa | bmask) : (qa & ~bmask);
		end
		`CBE_OP_REGISTER_COPY: begin
			wb_en = 1'b1;
			wb_data = rr_byte;
		end
		`CBE_OP_LOAD_IMMEDIATE: begin
			wb_en = 1'b1;
			wb_data = kval;
		end
		`CBE_OP_REGISTER_PAIR_COPY: ww_en = 1'b1;
		default: ;
		endcase
	end else if ((state == ST_SECOND) & is_load) begin
		wb_en = 1'b1;
		wb_data = dmem_rdata;
		ww_pair = ptr_pair(cmd[`CBE_CMD_P]);
		ww_data = ptr_new;
		ww_en = (op == `CBE_OP_INDIRECT_LOAD_INC) | (op == `CBE_OP_INDIRECT_LOAD_DEC);
	end else if (gpr_wr) begin
		wb_en = 1'b1;
		wb_addr = awaddr[6:2];
		wb_data = wdata[7:0];
	end
end

// **********************************************************
// Submodules
// **********************************************************
cbe_gpr u_gpr (
	.aclk(aclk),
	.a_addr(a_addr),
	.a_data(qa),
	.b_pair(cur_cmd[14:11]),
	.b_data(qb),
	.c_pair(ptr_pair(cur_cmd[`CBE_CMD_P])),
	.c_data(qc),
	.wb_en(wb_en),
	.wb_addr(wb_addr),
	.wb_data(wb_data),
	.ww_en(ww_en),
	.ww_pair(ww_pair),
	.ww_data(ww_data)
);

cbe_shift u_shift (
	.kind(op[1:0]),
	.value(qa),
	.carry_in(flags[`CBE_F_C]),
	.result(sh_res),
	.carry_out(sh_c),
	.zero(sh_z),
	.negative(sh_n),
	.overflow(sh_v)
);

endmodule // cbe_core

// ===== tb/cbe_monitor.sv
/* Concurrent checks on the execution core's bus and memory ports.
   Assumes one clock, aclk, with synchronous active-low aresetn. */
`timescale 1ns/1ps
module cbe_monitor (
	input wire aclk,
	input wire aresetn,
	input wire awvalid,
	input wire awready,
	input wire wvalid,
	input wire [1:0] bresp,
	input wire bvalid,
	input wire bready,
	input wire arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire rvalid,
	input wire rready,
	input wire dmem_rd,
	input wire [5:0] io_addr,
	input wire io_rd,
	input wire [7:0] io_rdata,
	input wire io_wr,
	input wire [7:0] io_wdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	write_answer_a: assert property (awvalid && wvalid && awready |=> bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	read_answer_a: assert property (arvalid && arready |=> !rvalid ##1 rvalid)
		else $error("read answer timing wrong");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	mem_pulse_a: assert property (dmem_rd |=> !dmem_rd)
		else $error("memory read longer than one cycle");
	io_rmw_a: assert property (io_rd |=> io_wr && $stable(io_addr))
		else $error("io write does not follow io read");
	io_one_bit_a: assert property (io_wr |-> $countones(io_wdata ^ $past(io_rdata)) <= 1)
		else $error("io write changes more than one bit");
	bus_apart_a: assert property (dmem_rd |-> !io_rd && !io_wr)
		else $error("memory and io access overlap");
endmodule // cbe_monitor

bind cbe_core cbe_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.dmem_rd(dmem_rd), .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata),
	.io_wr(io_wr), .io_wdata(io_wdata));

// ===== tb/cbe_mem.sv
/* Data memory and I/O space model answering in the strobe's cycle.
   Assumes the core's clock; memory data is a function of the address. */
`timescale 1ns/1ps
module cbe_mem (
	input wire aclk,
	input wire [15:0] dmem_addr,
	input wire dmem_rd,
	output wire [7:0] dmem_rdata,
	input wire [5:0] io_addr,
	input wire io_rd,
	output wire [7:0] io_rdata,
	input wire io_wr,
	input wire [7:0] io_wdata
);
	reg [7:0] io_mem [0:63];
	reg [7:0] junk;
	integer i;
	initial begin
		junk = 8'h00;
		for (i = 0; i < 64; i = i + 1)
			io_mem[i] = i[7:0] ^ 8'ha3;
	end
	// Unselected lines toggle so stale data is never mistaken for an answer
	always @(posedge aclk)
		junk <= ~junk;
	assign dmem_rdata = dmem_rd ? (dmem_addr[7:0] ^ dmem_addr[15:8] ^ 8'h5a) : junk;
	assign io_rdata = io_rd ? io_mem[io_addr] : junk;
	always @(posedge aclk)
		if (io_wr)
			io_mem[io_addr] <= io_wdata;
endmodule // cbe_mem

// ===== tb/cpu_bitops_branch_load_exec_tb.sv
/* Command-level bench: AXI4-Lite register tasks drive the core.
   Assumes cbe_map.vh on the include path and the cbe_mem model. */
`timescale 1ns/1ps
`include "cbe_map.vh"
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin error_cnt = error_cnt + 1; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module cpu_bitops_branch_load_exec_tb;
	localparam [1:0] ok = `CBE_RESP_OKAY;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [7:0] awaddr = 8'h00;
	reg awvalid = 1'b0;
	reg [31:0] wdata = 32'h0;
	reg wvalid = 1'b0;
	reg bready = 1'b0;
	reg [7:0] araddr = 8'h00;
	reg arvalid = 1'b0;
	reg rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, dmem_rd, io_rd, io_wr;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] dmem_addr;
	wire [7:0] dmem_rdata, io_rdata, io_wdata;
	wire [5:0] io_addr;
	integer error_cnt = 0;
	integer checks = 0;
	integer i, j;
	reg [31:0] v;
	reg [7:0] x, e, f;
	reg c;
	always #5 aclk = ~aclk;
	cbe_core i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
		.dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata),
		.io_wr(io_wr), .io_wdata(io_wdata));
	cbe_mem u_mem (.aclk(aclk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
		.dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_rd(io_rd), .io_rdata(io_rdata),
		.io_wr(io_wr), .io_wdata(io_wdata));
	// ************************************
	// Bus tasks
	// ************************************
	function [31:0] cw(input integer op, input integer d, input integer r, input integer b,
		input integer k);
		cw = {6'h0, k[7:0], b[2:0], r[4:0], d[4:0], op[4:0]};
	endfunction
	function [7:0] ga(input integer n);
		ga = `CBE_OFF_GPR + {n[4:0], 2'b00};
	endfunction
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			do @(posedge aclk); while (!(awready && wready));
			awvalid <= 1'b0;
			wvalid <= 1'b0;
			do @(posedge aclk); while (!bvalid);
			bready <= 1'b0;
			`CHK(bresp, er)
		end
	endtask
	task rd(input [7:0] a, output [31:0] d, input [1:0] er);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do @(posedge aclk); while (!arready);
			arvalid <= 1'b0;
			do @(posedge aclk); while (!rvalid);
			rready <= 1'b0;
			d = rdata;
			`CHK(rresp, er)
		end
	endtask
	task chk(input [7:0] a, input [31:0] ev);
		begin
			rd(a, v, ok);
			`CHK(v, ev)
		end
	endtask
	// Polls status until idle, then checks the cycle count of the command
	task run(input [31:0] cmd, input [1:0] cy);
		begin
			wr(`CBE_OFF_CMD, cmd, ok);
			v = 32'h1;
			while (v[`CBE_ST_BUSY])
				rd(`CBE_OFF_STATUS, v, ok);
			`CHK(v[`CBE_ST_CYC], cy)
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", checks, error_cnt);
			if (error_cnt == 0 && checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		#200000;
		error_cnt = error_cnt + 1;
		stop_test;
	end
	// ************************************
	// Tests
	// ************************************
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		chk(`CBE_OFF_FLAGS, 32'h0);
		chk(`CBE_OFF_PC, 32'h0);
		chk(`CBE_OFF_STATUS, 32'h0);
		rd(8'h40, v, `CBE_RESP_DECERR);
		`CHK(v, 32'h0)
		wr(`CBE_OFF_STATUS, 32'h0, `CBE_RESP_SLVERR);
		$display("test reset done");
		for (i = 0; i < 8; i = i + 1) begin
			run(cw(`CBE_OP_STATUS_FLAG_SET, 0, 0, i, 0), `CBE_CYC_ONE);
			chk(`CBE_OFF_FLAGS, (32'h2 << i) - 1);
		end
		for (i = 0; i < 8; i = i + 1) begin
			run(cw(`CBE_OP_STATUS_FLAG_CLEAR, 0, 0, i, 0), `CBE_CYC_ONE);
			chk(`CBE_OFF_FLAGS, (32'hff << (i + 1)) & 32'hff);
		end
		wr(`CBE_OFF_FLAGS, 32'hff, ok);
		run(cw(`CBE_OP_OVERFLOW_FLAG_CLEAR, 0, 0, 0, 0), `CBE_CYC_ONE);
		chk(`CBE_OFF_FLAGS, 32'hf7);
		wr(`CBE_OFF_FLAGS, 32'h0, ok);
		run(cw(`CBE_OP_HALF_CARRY_SET, 0, 0, 0, 0), `CBE_CYC_ONE);
		chk(`CBE_OFF_FLAGS, 32'h20);
		$display("test flags done");
		// Tested flag alone set, or every flag but it set, with a backward offset
		for (i = 1; i < 8; i = i + 1)
			for (j = 0; j < 2; j = j + 1) begin
				x = (i == 1) ? 8'h20 : (i < 4) ? 8'h40 : (i < 6) ? 8'h08 : 8'h80;
				f = j ? x : ~x;
				c = (j == ((i + 1) % 2));
				wr(`CBE_OFF_FLAGS, f, ok);
				wr(`CBE_OFF_PC, 32'h100, ok);
				run(cw(i, 0, 0, 0, 8'h7e), c ? `CBE_CYC_TWO : `CBE_CYC_ONE);
				chk(`CBE_OFF_PC, c ? 32'hff : 32'h101);
				chk(`CBE_OFF_FLAGS, f);
			end
		$display("test branch done");
		for (i = 0; i < 8; i = i + 1) begin
			x = i[2] ? 8'h01 : 8'h96;
			wr(ga(5), x, ok);
			wr(`CBE_OFF_FLAGS, 32'hf1, ok);
			case (i[1:0])
				2'd0: {c, e} = {x, 1'b0};
				2'd1: {e, c} = {1'b0, x};
				2'd2: {e, c} = {1'b1, x};
				default: {e, c} = {x[7], x};
			endcase
			f = {4'hf, e[7] ^ c, e[7], e == 8'h00, c};
			run(cw(`CBE_OP_LOGICAL_LEFT_SHIFT + i[1:0], 5, 0, 0, 0), `CBE_CYC_ONE);
			chk(ga(5), e);
			chk(`CBE_OFF_FLAGS, f);
		end
		$display("test shift done");
		wr(`CBE_OFF_FLAGS, 32'h1a, ok);
		wr(ga(3), 32'ha5, ok);
		run(cw(`CBE_OP_NIBBLE_EXCHANGE, 3, 0, 0, 0), `CBE_CYC_ONE);
		chk(ga(3), 32'h5a);
		chk(`CBE_OFF_FLAGS, 32'h1a);
		wr(ga(4), 32'h08, ok);
		run(cw(`CBE_OP_BIT_TO_TRANSFER_FLAG, 4, 0, 3, 0), `CBE_CYC_ONE);
		chk(`CBE_OFF_FLAGS, 32'h5a);
		wr(ga(6), 32'h80, ok);
		run(cw(`CBE_OP_TRANSFER_FLAG_TO_BIT, 6, 0, 0, 0), `CBE_CYC_ONE);
		chk(ga(6), 32'h81);
		wr(ga(5), 32'h33, ok);
		run(cw(`CBE_OP_REGISTER_COPY, 7, 3, 0, 0), `CBE_CYC_ONE);
		chk(ga(7), 32'h5a);
		run(cw(`CBE_OP_REGISTER_PAIR_COPY, 8, 4, 0, 0), `CBE_CYC_ONE);
		chk(ga(8), 32'h08);
		chk(ga(9), 32'h33);
		run(cw(`CBE_OP_LOAD_IMMEDIATE, 10, 0, 0, 8'h3c), `CBE_CYC_ONE);
		chk(ga(10), 32'h3c);
		chk(`CBE_OFF_FLAGS, 32'h5a);
		$display("test moves done");
		run(cw(`CBE_OP_IO_BIT_SET, 0, 0, 0, 5), `CBE_CYC_TWO);
		`CHK(u_mem.io_mem[5], 8'ha7)
		run(cw(`CBE_OP_IO_BIT_CLEAR, 0, 0, 2, 6), `CBE_CYC_TWO);
		`CHK(u_mem.io_mem[6], 8'ha1)
		chk(`CBE_OFF_FLAGS, 32'h5a);
		$display("test io done");
		wr(ga(26), 32'h10, ok);
		wr(ga(27), 32'h02, ok);
		run(cw(`CBE_OP_INDIRECT_LOAD_INC, 2, 0, 0, 0), `CBE_CYC_TWO);
		chk(ga(2), 32'h48);
		chk(ga(26), 32'h11);
		run(cw(`CBE_OP_INDIRECT_LOAD_DEC, 2, 0, 0, 0), `CBE_CYC_TWO);
		chk(ga(2), 32'h48);
		chk(ga(26), 32'h10);
		run(cw(`CBE_OP_DISPLACED_INDIRECT_LOAD, 2, 0, 0, 5), `CBE_CYC_TWO);
		chk(ga(2), 32'h4d);
		chk(ga(26), 32'h10);
		chk(`CBE_OFF_FLAGS, 32'h5a);
		$display("test load done");
		// Unknown code flags illegal; a following no-op clears it; both advance pc
		wr(`CBE_OFF_PC, 32'h10, ok);
		run(cw(5'h1f, 0, 0, 0, 0), `CBE_CYC_ONE);
		chk(`CBE_OFF_STATUS, 32'h12);
		run(cw(`CBE_OP_NOP, 0, 0, 0, 0), `CBE_CYC_ONE);
		chk(`CBE_OFF_STATUS, 32'h10);
		chk(`CBE_OFF_PC, 32'h12);
		chk(`CBE_OFF_FLAGS, 32'h5a);
		$display("test misc done");
		stop_test;
	end
endmodule // cpu_bitops_branch_load_exec_tb
